// >>> ffc_mem.sv
// ffc_mem: 9-bit wide storage array with combinational read port
// assumes caller never writes when full nor reads when empty
`timescale 1ns/1ns
module ffc_mem (
   input  wire logic                       clk_in,
   input  wire logic                       wr_en_in,
   input  wire logic [ffc_pkg::ADDR_W-1:0] wr_addr_in,
   input  wire logic [8:0]                 wr_data_in,
   input  wire logic [ffc_pkg::ADDR_W-1:0] rd_addr_in,
   output logic      [8:0]                 rd_data_out
);
   logic [8:0] store [ffc_pkg::DEPTH];

   // no reset on the array, so it maps onto block memory
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         store[wr_addr_in] <= wr_data_in;
      end
   end

   // combinational look-through; output register lives in the top
   assign rd_data_out = store[rd_addr_in];
endmodule

// >>> ffc_pkg.sv
// ffc_pkg: constants shared by the fifo reset-configuration and flag logic
// assumes a single 10 MHz clock domain and an apb register slave
package ffc_pkg;
   // memory geometry kept small for a model; counts in 9-bit units
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DEPTH  = 1 << ADDR_W;
   localparam logic [ADDR_W:0] HALF_LEVEL = 11'h200;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_WDATA  = 8'h0C;
   localparam logic [7:0] OFS_RDATA  = 8'h10;
   localparam logic [7:0] OFS_LEVEL  = 8'h14;
   localparam logic [7:0] OFS_AEMPTY = 8'h18;
   localparam logic [7:0] OFS_AFULL  = 8'h1C;

   // ctrl register fields
   localparam int unsigned CTRL_MRST_BIT   = 0;
   localparam int unsigned CTRL_OFSACC_BIT = 1;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

   // config capture fields
   localparam int unsigned CFG_ORDER_BIT  = 0;
   localparam int unsigned CFG_WWIDTH_BIT = 1;
   localparam int unsigned CFG_RWIDTH_BIT = 2;
   localparam int unsigned CFG_FALL_BIT   = 3;
   localparam int unsigned CFG_PARITY_BIT = 4;
   localparam int unsigned CFG_FTIME_BIT  = 5;
   localparam int unsigned CFG_RTLAT_BIT  = 6;
   localparam int unsigned CFG_SER_BIT  = 7;
   localparam int unsigned CFG_SEL_LSB  = 8;
   localparam logic [10:0] CFG_RESET    = 11'h000;

   // status fields
   localparam int unsigned ST_EMPTY_BIT = 0;
   localparam int unsigned ST_FULL_BIT  = 1;
   localparam int unsigned ST_HALF_BIT  = 2;
   localparam int unsigned ST_AEMPTY_BIT = 3;
   localparam int unsigned ST_AFULL_BIT  = 4;
   localparam int unsigned ST_MRST_BIT  = 5;

   // default offset table, indexed by {load, select 1, select 0}
   localparam logic [ADDR_W:0] DEF_OFS_0 = 11'h07F;
   localparam logic [ADDR_W:0] DEF_OFS_1 = 11'h0FF;
   localparam logic [ADDR_W:0] DEF_OFS_2 = 11'h1FF;
   localparam logic [ADDR_W:0] DEF_OFS_3 = 11'h03F;
   localparam logic [ADDR_W:0] DEF_OFS_4 = 11'h01F;
   localparam logic [ADDR_W:0] DEF_OFS_5 = 11'h00F;
   localparam logic [ADDR_W:0] DEF_OFS_6 = 11'h007;
   localparam logic [ADDR_W:0] DEF_OFS_7 = 11'h003;

   typedef enum logic [1:0] {
      FFC_IDLE  = 2'b00,
      FFC_SETUP = 2'b01,
      FFC_DONE  = 2'b11
   } ffc_apb_state_t;
endpackage

// >>> ffc_strap.sv
// ffc_strap: captures strapping levels while master reset is held
// assumes strap inputs are already synchronised to clk_in
`timescale 1ns/1ns
module ffc_strap (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        master_reset_in,
   input  wire logic [10:0] strap_in,
   output logic      [10:0] config_out
);
   // track while master reset holds; freeze at release until next one
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         config_out <= ffc_pkg::CFG_RESET;
      end else if (master_reset_in) begin
         config_out <= strap_in; // R22
      end
   end
endmodule

// >>> ffc_strap_drv.sv
// ffc_strap_drv: board-side logic that drives the strapping pins
// assumes the bench asks for new levels only through load_in
`timescale 1ns/1ns
module ffc_strap_drv (
   input  wire logic        clk_in,
   input  wire logic        load_in,
   input  wire logic [10:0] level_in,
   output logic      [10:0] strap_out
);
   // levels move only when asked and then stand still across master reset
   always_ff @(posedge clk_in) begin
      if (load_in)
         strap_out <= level_in;
   end
endmodule

// >>> ffc_top.sv
// ffc_top: fifo with strap capture at master reset and status flags
// assumes apb master on clk_in; strap pins are asynchronous
// Functional notes
// R1: byte order strap latched in master reset
// R2: x18 takes bits 0-17, x9 bits 0-8
// R3: writer holds bits 9-17 low in x9
// R4: standard mode: shared flag reports empty
// R5: fall-through mode: shared flag reports output ready
// R6: standard mode: shared flag reports full
// R7: fall-through mode: shared flag reports input space
// R8: offset selects plus load pick default offset
// R9: fall-through strap, then serial offset input; here the pin is only captured as a strap, with no serial offset load path
// R10: half-full flag reports level against half
// R11: parity placement strap latched in master reset
// R12: parity placement touches offset loading only
// R13: write width strap latched in master reset
// R14: load strap picks serial or parallel method
// R15: after reset load steers access to offsets
// R16: master reset zeroes pointers and output register
// R17: retransmit latency and flag timing captured
// R18: read width strap latched in master reset
// R19: flag timing strap latched in master reset
// R20: retransmit latency strap latched in master reset
// R21: straps held stable after master reset
// R22: straps registered at release, kept until next
// R23: shared flag function from captured mode only
`timescale 1ns/1ns
module ffc_top (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        byte_order_select_in,
   input  wire logic        write_width_select_in,
   input  wire logic        read_width_select_in,
   input  wire logic        fall_through_mode_in,
   input  wire logic        parity_placement_select_in,
   input  wire logic        flag_timing_select_in,
   input  wire logic        retransmit_latency_select_in,
   input  wire logic        offset_select_0_in,
   input  wire logic        offset_select_1_in,
   input  wire logic        offset_access_enable_in,
   output logic             empty_flag_out,
   output logic             full_flag_out,
   output logic             half_full_flag_out,
   output logic             almost_empty_flag_out,
   output logic             almost_full_flag_out
);
   localparam int unsigned AW = ffc_pkg::ADDR_W;

   logic [9:0]  pin_meta;
   logic [9:0]  pin_sync;
   logic [31:0] ctrl;
   logic        master_reset;
   logic [10:0] config_word;
   logic [10:0] strap_word;
   logic [AW:0] level;
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [17:0] out_reg;
   logic        out_valid;
   logic [AW:0] aempty_ofs;
   logic [AW:0] afull_ofs;
   logic [AW:0] next_def_ofs;
   logic [8:0]  mem_rd;
   logic        mem_we;
   logic [8:0]  mem_wd;
   logic        cfg_order;
   logic        cfg_x9_in;
   logic        cfg_x9_out;
   logic        cfg_fall;
   logic        cfg_parity;
   logic        cfg_serial;
   logic        offset_access;
   logic        wr_hit;
   logic        rd_hit;
   logic        push_pulse;
   logic        pop_pulse;
   logic [17:0] push_data;
   logic        push_hi;
   logic        pop_hi;
   logic [8:0]  push_lo_held;
   logic [1:0]  push_bytes;
   logic [1:0]  pop_bytes;
   logic        can_push;
   logic        can_pop;
   logic [31:0] next_rdata;
   logic        mem_empty;
   logic        mem_full;
   logic        load_par;
   ffc_pkg::ffc_apb_state_t apb_state;

   // two-stage synchroniser for every strap pin
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_meta <= 10'h000;
         pin_sync <= 10'h000;
      end else begin
         pin_meta <= {offset_access_enable_in, offset_select_1_in,
                      offset_select_0_in, retransmit_latency_select_in,
                      flag_timing_select_in, parity_placement_select_in,
                      fall_through_mode_in, read_width_select_in,
                      write_width_select_in, byte_order_select_in};
         pin_sync <= pin_meta;
      end
   end

   // strap word in config bit order; load doubles as method and offset
   assign strap_word = {pin_sync[9:7], pin_sync[9], pin_sync[6:0]};
   assign master_reset = ctrl[ffc_pkg::CTRL_MRST_BIT];

   ffc_strap u_strap (
      .clk_in          (clk_in),
      .sys_rst_in      (sys_rst_in),
      .master_reset_in (master_reset),
      .strap_in        (strap_word), // R1 R11 R13 R18 R19 R20 R14 R8
      .config_out      (config_word)
   );

   assign cfg_order  = config_word[ffc_pkg::CFG_ORDER_BIT];  // R1
   assign cfg_x9_in  = config_word[ffc_pkg::CFG_WWIDTH_BIT]; // R13
   assign cfg_x9_out = config_word[ffc_pkg::CFG_RWIDTH_BIT]; // R18
   assign cfg_fall   = config_word[ffc_pkg::CFG_FALL_BIT];   // R9
   assign cfg_parity = config_word[ffc_pkg::CFG_PARITY_BIT]; // R11
   assign cfg_serial = config_word[ffc_pkg::CFG_SER_BIT];  // R14
   // load pin only steers accesses outside master reset
   assign offset_access = ~master_reset & pin_sync[9]; // R15

   // default offset lookup from {load, select 1, select 0}
   always_comb begin
      case (config_word[ffc_pkg::CFG_SEL_LSB +: 3]) // R8
         3'h0:    next_def_ofs = ffc_pkg::DEF_OFS_0;
         3'h1:    next_def_ofs = ffc_pkg::DEF_OFS_1;
         3'h2:    next_def_ofs = ffc_pkg::DEF_OFS_2;
         3'h3:    next_def_ofs = ffc_pkg::DEF_OFS_3;
         3'h4:    next_def_ofs = ffc_pkg::DEF_OFS_4;
         3'h5:    next_def_ofs = ffc_pkg::DEF_OFS_5;
         3'h6:    next_def_ofs = ffc_pkg::DEF_OFS_6;
         default: next_def_ofs = ffc_pkg::DEF_OFS_7;
      endcase
   end

   // apb handshake: one wait state so config is stable before answer
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         apb_state <= ffc_pkg::FFC_IDLE;
      end else begin
         case (apb_state)
            ffc_pkg::FFC_IDLE:
               if (psel && !penable) apb_state <= ffc_pkg::FFC_SETUP;
            ffc_pkg::FFC_SETUP: apb_state <= ffc_pkg::FFC_DONE;
            ffc_pkg::FFC_DONE:  apb_state <= ffc_pkg::FFC_IDLE;
            default:            apb_state <= ffc_pkg::FFC_IDLE;
         endcase
      end
   end

   assign pready = (apb_state == ffc_pkg::FFC_DONE);
   assign pslverr = pready && paddr > ffc_pkg::OFS_AFULL;
   assign wr_hit = psel && penable && pready && pwrite;
   assign rd_hit = psel && penable && pready && !pwrite;

   // control register; master reset bit starts set
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl <= ffc_pkg::CTRL_RESET;
      end else if (wr_hit && paddr == ffc_pkg::OFS_CTRL) begin
         ctrl <= {31'h0, pwdata[ffc_pkg::CTRL_MRST_BIT]};
      end
   end

   // x9 writes store one byte; x18 writes take all 18 bits
   assign push_pulse = wr_hit && paddr == ffc_pkg::OFS_WDATA
                       && !master_reset && !offset_access;
   assign pop_pulse  = rd_hit && paddr == ffc_pkg::OFS_RDATA
                       && !master_reset && !offset_access;
   assign push_bytes = cfg_x9_in ? 2'h1 : 2'h2;
   assign pop_bytes  = cfg_x9_out ? 2'h1 : 2'h2;
   assign can_push = ({1'b0, level} + {10'h0, push_bytes})
                     <= 12'(ffc_pkg::DEPTH);
   assign can_pop = level >= {9'h0, pop_bytes};
   // x9 input uses bits 0-8 only; upper bits forced low here, whatever the writer drives
   assign push_data = cfg_x9_in ? {9'h0, pwdata[8:0]} // R2 R3
                                : pwdata[17:0];       // R2

   // byte sequencer: one memory byte per cycle; long words in two steps
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         push_hi <= 1'b0;
         push_lo_held <= 9'h000;
      end else if (master_reset) begin
         push_hi <= 1'b0;
         push_lo_held <= 9'h000;
      end else if (push_pulse && can_push && !cfg_x9_in) begin
         push_hi <= 1'b1;
         // big-endian (strap low) stores the high byte first
         push_lo_held <= cfg_order ? push_data[17:9] : push_data[8:0];
      end else begin
         push_hi <= 1'b0;
      end
   end

   assign mem_we = (push_pulse && can_push) || push_hi;
   assign mem_wd = push_hi ? push_lo_held
                 : (cfg_x9_in || cfg_order) ? push_data[8:0]
                 : push_data[17:9]; // R1

   // pointers, level and output register; master reset clears all
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
         out_reg <= 18'h00000;
         pop_hi <= 1'b0;
      end else if (master_reset) begin
         wr_ptr <= '0;          // R16
         rd_ptr <= '0;          // R16
         level <= '0;
         out_reg <= 18'h00000;  // R16
         pop_hi <= 1'b0;
      end else begin
         if (mem_we) wr_ptr <= wr_ptr + 1'b1;
         if ((pop_pulse && can_pop && !cfg_x9_out) || pop_hi) begin
            // second byte of an x18 read completes the word
            rd_ptr <= rd_ptr + 1'b1;
            pop_hi <= !pop_hi;
            if (!pop_hi && !cfg_order) out_reg[17:9] <= mem_rd;
            if (!pop_hi && cfg_order) out_reg[8:0] <= mem_rd;
            if (pop_hi && !cfg_order) out_reg[8:0] <= mem_rd;
            if (pop_hi && cfg_order) out_reg[17:9] <= mem_rd;
         end else if (pop_pulse && can_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
            out_reg <= {9'h000, mem_rd};
         end
         level <= level + {{AW{1'b0}}, mem_we}
                  - {{AW{1'b0}}, (pop_pulse && can_pop) || pop_hi};
      end
   end

   ffc_mem u_mem (
      .clk_in      (clk_in),
      .wr_en_in    (mem_we),
      .wr_addr_in  (wr_ptr),
      .wr_data_in  (mem_wd), // R12
      .rd_addr_in  (rd_ptr),
      .rd_data_out (mem_rd)
   );

   // offset registers: defaults at master reset, apb load later
   assign load_par = wr_hit && offset_access && !cfg_serial;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         aempty_ofs <= ffc_pkg::DEF_OFS_0;
         afull_ofs <= ffc_pkg::DEF_OFS_0;
      end else if (master_reset) begin
         aempty_ofs <= next_def_ofs; // R8
         afull_ofs <= next_def_ofs;
      end else if (load_par && paddr == ffc_pkg::OFS_AEMPTY) begin
         // interspersed parity skips bit 8 of the parallel word
         aempty_ofs <= cfg_parity ? {pwdata[11:9], pwdata[7:0]} // R12
                                  : pwdata[AW:0];
      end else if (load_par && paddr == ffc_pkg::OFS_AFULL) begin
         afull_ofs <= cfg_parity ? {pwdata[11:9], pwdata[7:0]}
                                 : pwdata[AW:0];
      end
   end

   // output valid registers a nonzero fifo level, one cycle behind it
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) out_valid <= 1'b0;
      else if (master_reset) out_valid <= 1'b0;
      else out_valid <= (level != '0);
   end

   assign mem_empty = (level == '0);
   assign mem_full  = !can_push;

   // shared flags chosen only from captured timing mode; active low
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         empty_flag_out <= 1'b0;
         full_flag_out <= 1'b0;
         half_full_flag_out <= 1'b1;
         almost_empty_flag_out <= 1'b0;
         almost_full_flag_out <= 1'b1;
      end else begin
         empty_flag_out <= cfg_fall ? !out_valid  // R5 R23
                                    : !mem_empty; // R4 R23
         full_flag_out <= cfg_fall ? mem_full     // R7 R23
                                   : !mem_full;   // R6 R23
         half_full_flag_out <= !(level > ffc_pkg::HALF_LEVEL); // R10
         almost_empty_flag_out <= level >= aempty_ofs;
         almost_full_flag_out <=
            (11'(ffc_pkg::DEPTH) - level) > afull_ofs;
      end
   end

   // read mux and read data register
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         ffc_pkg::OFS_CTRL:   next_rdata = ctrl;
         ffc_pkg::OFS_CONFIG: next_rdata = {21'h0, config_word}; // R17
         ffc_pkg::OFS_STATUS: next_rdata = {26'h0, master_reset,
            almost_full_flag_out, almost_empty_flag_out,
            half_full_flag_out, full_flag_out, empty_flag_out};
         ffc_pkg::OFS_RDATA:  next_rdata = {14'h0, out_reg};
         ffc_pkg::OFS_LEVEL:  next_rdata = {21'h0, level};
         ffc_pkg::OFS_AEMPTY: next_rdata = {21'h0, aempty_ofs};
         ffc_pkg::OFS_AFULL:  next_rdata = {21'h0, afull_ofs};
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) prdata <= 32'h0000_0000;
      else if (apb_state == ffc_pkg::FFC_SETUP) prdata <= next_rdata;
   end
endmodule

// >>> ffc_top_assertions.sv
// ffc_top_assertions: port-level checks for the fifo strap and flag block
// assumes binding onto ffc_top and an apb master that waits for pready
`timescale 1ns/1ns
module ffc_chk (
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        fall_through_mode_in,
   input wire logic        empty_flag_out,
   input wire logic        full_flag_out,
   input wire logic        half_full_flag_out
);
   logic [2:0] quiet;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   // cycles since a transfer or a mode strap edge; saturates so it stays small
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         quiet <= 3'h0;
      else if (psel && penable && pready)
         quiet <= 3'h0;
      else if ($changed(fall_through_mode_in))
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;
   end

   apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not after exactly one wait state");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   err_decode_a: assert property (pready |-> pslverr == (paddr > 8'h1C))
      else $error("pslverr does not match the address decode");
   rdata_hold_a: assert property (!psel |=> $stable(prdata))
      else $error("prdata moved without a transfer");
   rst_flags_a: assert property (disable iff (1'b0)
      sys_rst_in |-> !empty_flag_out && !full_flag_out
         && half_full_flag_out && prdata == 32'h0)
      else $error("outputs not at reset levels");
   empty_cause_a: assert property ($changed(empty_flag_out) |-> quiet < 3'h7)
      else $error("empty flag moved with no cause");
   full_cause_a: assert property ($changed(full_flag_out) |-> quiet < 3'h7)
      else $error("full flag moved with no cause");
   half_cause_a: assert property ($changed(half_full_flag_out)
      |-> quiet < 3'h7)
      else $error("half flag moved with no cause");
endmodule

bind ffc_top ffc_chk i_chk (.clk_in, .sys_rst_in, .psel, .penable, .paddr,
   .prdata, .pready, .pslverr, .fall_through_mode_in, .empty_flag_out,
   .full_flag_out, .half_full_flag_out);

// >>> ffc_top_tb_top.sv
// ffc_top_tb_top: apb-driven bench for strap capture and status flags
// assumes ffc_top with one 10 MHz clock; straps come from ffc_strap_drv
`timescale 1ns/1ns
module ffc_top_tb_top;
   logic        clk_in, sys_rst_in, psel, penable, pwrite, pready, pslverr;
   logic        s_load, err, e_flag, f_flag, h_flag, ser0;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [10:0] s_lvl, strap, v;
   logic [10:0] dofs [8];
   int          failures, check_count, cyc;

   ffc_strap_drv i_strap (.clk_in(clk_in), .load_in(s_load),
      .level_in(s_lvl), .strap_out(strap));
   ffc_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .byte_order_select_in(strap[0]), .write_width_select_in(strap[1]),
      .read_width_select_in(strap[2]), .fall_through_mode_in(strap[3]),
      .parity_placement_select_in(strap[4]),
      .flag_timing_select_in(strap[5]),
      .retransmit_latency_select_in(strap[6]),
      .offset_select_0_in(strap[8]), .offset_select_1_in(strap[9]),
      .offset_access_enable_in(strap[10]), .empty_flag_out(e_flag),
      .full_flag_out(f_flag), .half_full_flag_out(h_flag),
      .almost_empty_flag_out(), .almost_full_flag_out());

   // 100 ns clock
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // a run far past the expected ~8k cycles is a hang
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, exp, input string m);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1);
      chk(n, 32'h2, "wait states");
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next call never re-drives psel in this step
      @(posedge clk_in);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask

   task automatic set_straps(input logic [10:0] x);
      s_lvl  <= x;
      s_load <= 1'b1;
      @(posedge clk_in);
      s_load <= 1'b0;
   endtask

   // straps settle, master reset held a few cycles, then released
   task automatic mreset(input logic [10:0] x);
      set_straps(x);
      apb(1'b1, ffc_pkg::OFS_CTRL, 32'h1);
      repeat (4) @(posedge clk_in);
      apb(1'b1, ffc_pkg::OFS_CTRL, 32'h0);
      repeat (3) @(posedge clk_in);
   endtask

   task automatic wr(input logic [31:0] d);
      apb(1'b1, ffc_pkg::OFS_WDATA, d);
      repeat (3) @(posedge clk_in);
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      s_lvl = 11'h000;
      s_load = 1'b1;
      sys_rst_in <= 1'b1;
      dofs = '{ffc_pkg::DEF_OFS_0, ffc_pkg::DEF_OFS_1, ffc_pkg::DEF_OFS_2,
         ffc_pkg::DEF_OFS_3, ffc_pkg::DEF_OFS_4, ffc_pkg::DEF_OFS_5,
         ffc_pkg::DEF_OFS_6, ffc_pkg::DEF_OFS_7};
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      s_load <= 1'b0;
      rdc(ffc_pkg::OFS_CTRL, 32'h1, "ctrl at reset");
      // every offset select code with varied mode straps
      for (int k = 0; k < 8; k++) begin
         v = {k[2:0], 8'h00} | (k[0] ? 11'h07F : (k[1] ? 11'h02A : 11'h055));
         mreset(v);
         apb(1'b0, ffc_pkg::OFS_CONFIG, 32'h0);
         chk(rd & 32'h77F, {21'h0, v & 11'h77F}, "config");
         if (k == 0)
            ser0 = rd[7];
         if (k == 4)
            chk({31'h0, rd[7] ^ ser0}, 32'h1, "method");
         rdc(ffc_pkg::OFS_AEMPTY, {21'h0, dofs[k]}, "empty ofs");
         rdc(ffc_pkg::OFS_AFULL, {21'h0, dofs[k]}, "full ofs");
      end
      // straps moved after release must not reach the capture
      set_straps(~v);
      repeat (6) @(posedge clk_in);
      rdc(ffc_pkg::OFS_CONFIG, {21'h0, v[10:8], v[10], v[6:0]},
          "held config");
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      $display("test straps done");

      mreset(11'h006);
      chk({29'h0, e_flag, f_flag, h_flag}, 32'h3, "std flags");
      rdc(ffc_pkg::OFS_STATUS, 32'h16, "status");
      wr(32'h0000_01A5);
      chk({31'h0, e_flag}, 32'h1, "not empty");
      set_straps(11'h406);
      wr(32'h0000_0055);
      set_straps(11'h006);
      rdc(ffc_pkg::OFS_LEVEL, 32'h1, "load steers write");
      apb(1'b0, ffc_pkg::OFS_RDATA, 32'h0);
      rdc(ffc_pkg::OFS_RDATA, 32'h1A5, "x9 word");
      chk({31'h0, e_flag}, 32'h0, "empty again");
      for (int i = 1; i <= 1024; i++) begin
         wr({23'h0, i[8:0]});
         if (i == 512 || i == 513)
            chk({31'h0, h_flag}, {31'h0, i == 512}, "half flag");
         if (i == 1023 || i == 1024)
            chk({31'h0, f_flag}, {31'h0, i == 1023}, "full flag");
      end
      wr(32'h0000_0011);
      rdc(ffc_pkg::OFS_LEVEL, 32'h400, "write when full");
      mreset(11'h006);
      rdc(ffc_pkg::OFS_LEVEL, 32'h0, "pointers cleared");
      rdc(ffc_pkg::OFS_RDATA, 32'h0, "output cleared");
      $display("test standard done");

      // x18 in, x9 out, both byte orders
      for (int b = 0; b < 2; b++) begin
         mreset(11'h004 | 11'(b));
         wr({14'h0, 9'h1C3, 9'h02D});
         rdc(ffc_pkg::OFS_LEVEL, 32'h2, "x18 is two units");
         apb(1'b0, ffc_pkg::OFS_RDATA, 32'h0);
         apb(1'b0, ffc_pkg::OFS_RDATA, 32'h0);
         chk(rd, b ? 32'h02D : 32'h1C3, "first unit");
         rdc(ffc_pkg::OFS_RDATA, b ? 32'h1C3 : 32'h02D, "second unit");
      end
      $display("test byte order done");

      mreset(11'h00E);
      chk({31'h0, f_flag}, 32'h0, "input space");
      chk({31'h0, e_flag}, 32'h1, "no output yet");
      wr(32'h0000_0123);
      repeat (4) @(posedge clk_in);
      chk({31'h0, e_flag}, 32'h0, "output ready");
      $display("test fall through done");
      close_out();
   end
endmodule
